// ### ocfg_defines.svh
`ifndef OCFG_DEFINES_SVH
`define OCFG_DEFINES_SVH

// Register offsets in the second register space
`define OCFG_ADDR_MODE      32'h00000000
`define OCFG_ADDR_STROBE    32'h00000200
`define OCFG_ADDR_DUMMY     32'h00000300
`define OCFG_ADDR_ECS       32'h00000400
`define OCFG_ADDR_CHECK     32'h00000500
`define OCFG_ADDR_ECC       32'h00000800
`define OCFG_ADDR_HALF_BIT  26

// Writable bits of each register, reserved bits masked off
`define OCFG_MASK_CR        8'h1F
`define OCFG_MASK_MODE      8'h03
`define OCFG_MASK_STROBE    8'h03
`define OCFG_MASK_DUMMY     8'h07
`define OCFG_MASK_ECS       8'h03
`define OCFG_MASK_CHECK     8'h71

// Drive/protect/preamble register field positions
`define OCFG_CR_DRIVE_LSB   0
`define OCFG_CR_DRIVE_MSB   2
`define OCFG_CR_SIDE_BIT    3
`define OCFG_CR_PRE_BIT     4

// Field positions in the second register space
`define OCFG_STB_SR_BIT     1
`define OCFG_STB_PRC_BIT    0
`define OCFG_CHK_SIZE_LSB   5
`define OCFG_CHK_SIZE_MSB   6
`define OCFG_CHK_OUT_BIT    4
`define OCFG_CHK_PAT_BIT    0
`define OCFG_ECC_VALID_BIT  7

// Reset values
`define OCFG_RST_DRIVE      3'h7
`define OCFG_RST_SIDE       1'b0
`define OCFG_RST_PRE        1'b0
`define OCFG_RST_MODE       2'h0
`define OCFG_RST_DUMMY      3'h0
`define OCFG_RST_ECS        2'h0
`define OCFG_RST_SIZE       2'h0
`define OCFG_RST_FS         3'h0
`define OCFG_RST_CNT        4'h0
`define OCFG_RST_FLAG       1'b0
`define OCFG_RST_IMAGE      64'h0000000000000007

// Derived timing and size figures
`define OCFG_DUMMY_BASE     5'h14
`define OCFG_CHUNK_BASE     8'h10
`define OCFG_CNT_MAX        4'hF

// Preamble patterns, one bit per dummy cycle, MSB first
`define OCFG_PAT0_MAIN      16'h349A
`define OCFG_PAT0_LINE3     16'h3514
`define OCFG_PAT1_ALL       16'h5555

`endif

// ### ocfg_pkg.sv
`default_nettype none
`include "ocfg_defines.svh"

package ocfg_pkg;

  // Interface mode encoding
  typedef enum logic [1:0] {
    OCFG_MODE_SERIAL = 2'h0,
    OCFG_MODE_STR    = 2'h1,
    OCFG_MODE_DTR    = 2'h2,
    OCFG_MODE_RSVD   = 2'h3
  } ocfg_mode_t;

  // Registers of the addressed space
  typedef enum logic [2:0] {
    OCFG_REG_NONE, OCFG_REG_MODE, OCFG_REG_STROBE, OCFG_REG_DUMMY,
    OCFG_REG_ECS, OCFG_REG_CHECK, OCFG_REG_ECC_LO, OCFG_REG_ECC_HI
  } ocfg_reg_t;

  // Address decode shared by the write and read paths
  function automatic ocfg_reg_t ocfg_decode(input logic [31:0] addr);
    logic [31:0] base;
    logic        upper;
    base  = addr & ~(32'h1 << `OCFG_ADDR_HALF_BIT);
    upper = addr[`OCFG_ADDR_HALF_BIT];
    ocfg_decode = OCFG_REG_NONE;
    if (base == `OCFG_ADDR_ECC) begin
      ocfg_decode = upper ? OCFG_REG_ECC_HI : OCFG_REG_ECC_LO;
    end else if (!upper) begin
      case (base)
        `OCFG_ADDR_MODE:   ocfg_decode = OCFG_REG_MODE;
        `OCFG_ADDR_STROBE: ocfg_decode = OCFG_REG_STROBE;
        `OCFG_ADDR_DUMMY:  ocfg_decode = OCFG_REG_DUMMY;
        `OCFG_ADDR_ECS:    ocfg_decode = OCFG_REG_ECS;
        `OCFG_ADDR_CHECK:  ocfg_decode = OCFG_REG_CHECK;
        default:           ocfg_decode = OCFG_REG_NONE;
      endcase
    end
  endfunction

endpackage

`default_nettype wire

// ### ocfg_link_port.sv
`default_nettype none
`include "ocfg_defines.svh"

module ocfg_link_port (
  // Link clock and reset
  input  wire logic        link_clk_i,
  input  wire logic        link_reset_i,
  // Register access from the command decoder
  input  wire logic        wr_status_i,
  input  wire logic        wr_cfg2_i,
  input  wire logic [31:0] wr_addr_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        rd_cfg_reg_i,
  input  wire logic [31:0] rd_addr_i,
  output logic      [7:0]  rd_data_o,
  // Toward the core domain
  output logic             req_tgl_o,
  output logic             req_status_o,
  output logic      [31:0] req_addr_o,
  output logic      [7:0]  req_data_o,
  // Register image from the core domain
  input  wire logic [63:0] image_i
);
  import ocfg_pkg::*;

  logic        tgl_q, tgl_d;
  logic        status_q, status_d;
  logic [31:0] addr_q, addr_d;
  logic [7:0]  data_q, data_d;
  logic [63:0] img_meta_q, img_q;
  logic [7:0]  rd_q, rd_d;

  // Capture a write and flip the toggle; held until the next write
  always_comb begin
    tgl_d    = tgl_q;
    status_d = status_q;
    addr_d   = addr_q;
    data_d   = data_q;
    if (wr_status_i || wr_cfg2_i) begin
      tgl_d    = ~tgl_q;
      status_d = wr_status_i;
      addr_d   = wr_addr_i;
      data_d   = wr_data_i;
    end
  end

  // Read mux over the synchronised image
  always_comb begin
    rd_d = 8'h00;
    if (rd_cfg_reg_i) begin
      rd_d = img_q[7:0];
    end else begin
      unique case (ocfg_decode(rd_addr_i))
        OCFG_REG_MODE:   rd_d = img_q[15:8];
        OCFG_REG_STROBE: rd_d = img_q[23:16];
        OCFG_REG_DUMMY:  rd_d = img_q[31:24];
        OCFG_REG_ECS:    rd_d = img_q[39:32];
        OCFG_REG_CHECK:  rd_d = img_q[47:40];
        OCFG_REG_ECC_LO: rd_d = img_q[55:48];
        OCFG_REG_ECC_HI: rd_d = img_q[63:56];
        OCFG_REG_NONE:   rd_d = 8'h00;
      endcase
    end
  end

  // Link-domain registers; image passes two flip-flops
  always_ff @(posedge link_clk_i) begin
    if (link_reset_i) begin
      tgl_q      <= 1'b0;
      status_q   <= 1'b0;
      addr_q     <= 32'h00000000;
      data_q     <= 8'h00;
      img_meta_q <= 64'h0000000000000000;
      img_q      <= 64'h0000000000000000;
      rd_q       <= 8'h00;
    end else begin
      tgl_q      <= tgl_d;
      status_q   <= status_d;
      addr_q     <= addr_d;
      data_q     <= data_d;
      img_meta_q <= image_i;
      img_q      <= img_meta_q;
      rd_q       <= rd_d;
    end
  end

  assign req_tgl_o    = tgl_q;
  assign req_status_o = status_q;
  assign req_addr_o   = addr_q;
  assign req_data_o   = data_q;
  assign rd_data_o    = rd_q;

endmodule

`default_nettype wire

// ### ocfg_regs.sv
// Operation
// - New settings take effect right after write
// - Three-bit volatile drive strength, 146 to 24 ohms
// - Drive, side, preamble change only by status-write command
// - Side bit 0 protects top, 1 bottom
// - Side bit one-time programmable, delivered as 0
// - Preamble enable drives pattern in dummy cycles
// - Mode field: serial, single-rate or double-rate octal
// - Error pin condition field, default 00
// - Check chunk size 16 to 128 bytes
// - Bit 4 enables check output pin
// - Valid bit set when failing chunk recorded
// - Three-bit error status, zero means none
// - Four-bit failing-chunk counter, reset zero
// - Counter saturates at 15, counts rereads
// - Separate error status for each array half
// - Dummy field gives 20 down to 6 cycles
// - Preamble pattern chosen by select bit
`default_nettype none
`include "ocfg_defines.svh"

module ocfg_regs (
  // Core clock and reset
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  // Link clock and reset
  input  wire logic              link_clk_i,
  input  wire logic              link_reset_i,
  // Register access on the link clock
  input  wire logic              wr_status_i,
  input  wire logic              wr_cfg2_i,
  input  wire logic [31:0]       wr_addr_i,
  input  wire logic [7:0]        wr_data_i,
  input  wire logic              rd_cfg_reg_i,
  input  wire logic [31:0]       rd_addr_i,
  output logic      [7:0]        rd_data_o,
  // Error events from the array read path
  input  wire logic              ecc_event_i,
  input  wire logic              ecc_upper_i,
  input  wire logic [2:0]        ecc_kind_i,
  // Settings applied to the device
  output logic      [2:0]        drive_strength_sel_o,
  output logic                   protect_region_side_o,
  output logic                   preamble_output_en_o,
  output ocfg_pkg::ocfg_mode_t   interface_mode_o,
  output logic                   strobe_single_rate_en_o,
  output logic                   strobe_precycle_o,
  output logic      [4:0]        dummy_cycles_o,
  output logic      [1:0]        error_pin_condition_o,
  output logic      [7:0]        check_chunk_bytes_o,
  output logic                   check_output_en_o,
  output logic      [15:0]       preamble_pattern_o,
  output logic      [15:0]       preamble_pattern_line3_o,
  output logic                   ecc_error_pin_n_o
);
  import ocfg_pkg::*;

  // Crossing wires from the link port
  logic        req_tgl;
  logic        req_status;
  logic [31:0] req_addr;
  logic [7:0]  req_data;
  logic        tgl_meta_q, tgl_sync_q, tgl_seen_q;
  logic        req_edge;

  // Configuration state
  logic [2:0]  drive_q, drive_d;
  logic        side_q, side_d;
  logic        pre_en_q, pre_en_d;
  ocfg_mode_t  mode_q, mode_d;
  logic        stb_sr_q, stb_sr_d;
  logic        stb_prc_q, stb_prc_d;
  logic [2:0]  dummy_sel_q, dummy_sel_d;
  logic [1:0]  ecs_q, ecs_d;
  logic [1:0]  chunk_sel_q, chunk_sel_d;
  logic        chk_out_q, chk_out_d;
  logic        pat_sel_q, pat_sel_d;

  // Error status, one entry per array half
  logic        valid_q [2];
  logic        valid_d [2];
  logic [2:0]  fs_q [2];
  logic [2:0]  fs_d [2];
  logic [3:0]  cnt_q [2];
  logic [3:0]  cnt_d [2];

  // Derived outputs and image
  logic [4:0]  dummy_cyc_q, dummy_cyc_d;
  logic [7:0]  chunk_bytes_q, chunk_bytes_d;
  logic [15:0] pat_q, pat_d;
  logic [15:0] pat3_q, pat3_d;
  logic        err_pin_n_q, err_pin_n_d;
  logic [63:0] image_q, image_d;

  // Error pin condition met by one status field
  // Condition 11 ignores double programming; 10 sees two-bit errors only
  function automatic logic ocfg_pin_hit(input logic [1:0] cond, input logic [2:0] fs);
    unique case (cond)
      2'h0:    ocfg_pin_hit = fs[1] | fs[2];
      2'h1:    ocfg_pin_hit = |fs;
      2'h2:    ocfg_pin_hit = fs[1];
      2'h3:    ocfg_pin_hit = fs[0] | fs[1];
    endcase
  endfunction

  // Status byte of one half
  function automatic logic [7:0] ocfg_ecc_byte(input logic v, input logic [2:0] fs,
                                               input logic [3:0] cnt);
    ocfg_ecc_byte = {v, fs, cnt};
  endfunction

  // Link-domain capture and read-back
  ocfg_link_port u_link (
    .link_clk_i   (link_clk_i),
    .link_reset_i (link_reset_i),
    .wr_status_i  (wr_status_i),
    .wr_cfg2_i    (wr_cfg2_i),
    .wr_addr_i    (wr_addr_i),
    .wr_data_i    (wr_data_i),
    .rd_cfg_reg_i (rd_cfg_reg_i),
    .rd_addr_i    (rd_addr_i),
    .rd_data_o    (rd_data_o),
    .req_tgl_o    (req_tgl),
    .req_status_o (req_status),
    .req_addr_o   (req_addr),
    .req_data_o   (req_data),
    .image_i      (image_q)
  );

  // Toggle synchroniser; fields are stable when the edge is seen
  // The link side holds address and data until the next write, and the
  // toggle reaches the core two edges after them, so the bundled fields
  // need no synchroniser of their own; writes closer than two core
  // cycles may merge into one
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_meta_q <= req_tgl;
      tgl_sync_q <= tgl_meta_q;
      tgl_seen_q <= tgl_sync_q;
    end
  end

  assign req_edge = tgl_sync_q ^ tgl_seen_q;

  // Register writes
  always_comb begin
    drive_d     = drive_q;
    side_d      = side_q;
    pre_en_d    = pre_en_q;
    mode_d      = mode_q;
    stb_sr_d    = stb_sr_q;
    stb_prc_d   = stb_prc_q;
    dummy_sel_d = dummy_sel_q;
    ecs_d       = ecs_q;
    chunk_sel_d = chunk_sel_q;
    chk_out_d   = chk_out_q;
    pat_sel_d   = pat_sel_q;
    if (req_edge) begin
      if (req_status) begin
        drive_d  = req_data[`OCFG_CR_DRIVE_MSB:`OCFG_CR_DRIVE_LSB];
        // Protect side is set-only: a written zero never clears it
        side_d   = side_q | req_data[`OCFG_CR_SIDE_BIT];
        pre_en_d = req_data[`OCFG_CR_PRE_BIT];
      end else begin
        unique case (ocfg_decode(req_addr))
          OCFG_REG_MODE: begin
            mode_d = ocfg_mode_t'(req_data[1:0]);
          end
          OCFG_REG_STROBE: begin
            stb_sr_d  = req_data[`OCFG_STB_SR_BIT];
            stb_prc_d = req_data[`OCFG_STB_PRC_BIT];
          end
          OCFG_REG_DUMMY: begin
            dummy_sel_d = req_data[2:0];
          end
          OCFG_REG_ECS: begin
            ecs_d = req_data[1:0];
          end
          OCFG_REG_CHECK: begin
            chunk_sel_d = req_data[`OCFG_CHK_SIZE_MSB:`OCFG_CHK_SIZE_LSB];
            chk_out_d   = req_data[`OCFG_CHK_OUT_BIT];
            pat_sel_d   = req_data[`OCFG_CHK_PAT_BIT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Error status per half; saturating counter
  // Status bits only accumulate and clear on reset alone; the counter
  // stops at its maximum instead of wrapping back to zero
  always_comb begin
    for (int h = 0; h < 2; h++) begin
      valid_d[h] = valid_q[h];
      fs_d[h]    = fs_q[h];
      cnt_d[h]   = cnt_q[h];
      if (ecc_event_i && (ecc_upper_i == h[0]) && (ecc_kind_i != 3'h0)) begin
        valid_d[h] = 1'b1;
        fs_d[h]    = fs_q[h] | ecc_kind_i;
        if (cnt_q[h] != `OCFG_CNT_MAX) begin
          cnt_d[h] = cnt_q[h] + 4'h1;
        end
      end
    end
  end

  // Settings decoded for the device and the read image
  // Decoded from next values so they move on the same edge as their field
  // The image reaches the link side through two flip-flops per bit; it
  // changes only on writes and events, so a read racing one may see old, new or mixed bits
  always_comb begin
    dummy_cyc_d   = `OCFG_DUMMY_BASE - {1'b0, dummy_sel_d, 1'b0};
    chunk_bytes_d = `OCFG_CHUNK_BASE << chunk_sel_d;
    pat_d         = pat_sel_d ? `OCFG_PAT1_ALL : `OCFG_PAT0_MAIN;
    pat3_d        = pat_sel_d ? `OCFG_PAT1_ALL : `OCFG_PAT0_LINE3;
    err_pin_n_d   = ~(ocfg_pin_hit(ecs_d, fs_d[0]) | ocfg_pin_hit(ecs_d, fs_d[1]));
    image_d[7:0]   = {3'h0, pre_en_d, side_d, drive_d} & `OCFG_MASK_CR;
    image_d[15:8]  = {6'h00, mode_d} & `OCFG_MASK_MODE;
    image_d[23:16] = {6'h00, stb_sr_d, stb_prc_d} & `OCFG_MASK_STROBE;
    image_d[31:24] = {5'h00, dummy_sel_d} & `OCFG_MASK_DUMMY;
    image_d[39:32] = {6'h00, ecs_d} & `OCFG_MASK_ECS;
    image_d[47:40] = {1'b0, chunk_sel_d, chk_out_d, 3'h0, pat_sel_d} & `OCFG_MASK_CHECK;
    image_d[55:48] = ocfg_ecc_byte(valid_d[0], fs_d[0], cnt_d[0]);
    image_d[63:56] = ocfg_ecc_byte(valid_d[1], fs_d[1], cnt_d[1]);
  end

  // Core-domain registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      drive_q       <= `OCFG_RST_DRIVE;
      side_q        <= `OCFG_RST_SIDE;
      pre_en_q      <= `OCFG_RST_PRE;
      mode_q        <= ocfg_mode_t'(`OCFG_RST_MODE);
      stb_sr_q      <= `OCFG_RST_FLAG;
      stb_prc_q     <= `OCFG_RST_FLAG;
      dummy_sel_q   <= `OCFG_RST_DUMMY;
      ecs_q         <= `OCFG_RST_ECS;
      chunk_sel_q   <= `OCFG_RST_SIZE;
      chk_out_q     <= `OCFG_RST_FLAG;
      pat_sel_q     <= `OCFG_RST_FLAG;
      for (int h = 0; h < 2; h++) begin
        valid_q[h] <= 1'b0;
        fs_q[h]    <= `OCFG_RST_FS;
        cnt_q[h]   <= `OCFG_RST_CNT;
      end
      dummy_cyc_q   <= `OCFG_DUMMY_BASE;
      chunk_bytes_q <= `OCFG_CHUNK_BASE;
      pat_q         <= `OCFG_PAT0_MAIN;
      pat3_q        <= `OCFG_PAT0_LINE3;
      err_pin_n_q   <= 1'b1;
      image_q       <= `OCFG_RST_IMAGE;
    end else begin
      drive_q       <= drive_d;
      side_q        <= side_d;
      pre_en_q      <= pre_en_d;
      mode_q        <= mode_d;
      stb_sr_q      <= stb_sr_d;
      stb_prc_q     <= stb_prc_d;
      dummy_sel_q   <= dummy_sel_d;
      ecs_q         <= ecs_d;
      chunk_sel_q   <= chunk_sel_d;
      chk_out_q     <= chk_out_d;
      pat_sel_q     <= pat_sel_d;
      for (int h = 0; h < 2; h++) begin
        valid_q[h] <= valid_d[h];
        fs_q[h]    <= fs_d[h];
        cnt_q[h]   <= cnt_d[h];
      end
      dummy_cyc_q   <= dummy_cyc_d;
      chunk_bytes_q <= chunk_bytes_d;
      pat_q         <= pat_d;
      pat3_q        <= pat3_d;
      err_pin_n_q   <= err_pin_n_d;
      image_q       <= image_d;
    end
  end

  // Settings drive the device from flip-flops; timing
  assign drive_strength_sel_o     = drive_q;
  assign protect_region_side_o    = side_q;
  assign preamble_output_en_o     = pre_en_q;
  assign interface_mode_o         = mode_q;
  assign strobe_single_rate_en_o  = stb_sr_q;
  assign strobe_precycle_o        = stb_prc_q;
  assign dummy_cycles_o           = dummy_cyc_q;
  assign error_pin_condition_o    = ecs_q;
  assign check_chunk_bytes_o      = chunk_bytes_q;
  assign check_output_en_o        = chk_out_q;
  assign preamble_pattern_o       = pat_q;
  assign preamble_pattern_line3_o = pat3_q;
  assign ecc_error_pin_n_o        = err_pin_n_q;

endmodule

`default_nettype wire

// ### ocfg_regs_properties.sv
`default_nettype none

module ocfg_regs_checker (
  // Clocks and resets
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        link_clk_i,
  input wire logic        link_reset_i,
  // Watched ports
  input wire logic        rd_cfg_reg_i,
  input wire logic [31:0] rd_addr_i,
  input wire logic [7:0]  rd_data_o,
  input wire logic        ecc_event_i,
  input wire logic [2:0]  ecc_kind_i,
  input wire logic [2:0]  drive_strength_sel_o,
  input wire logic        protect_region_side_o,
  input wire logic        preamble_output_en_o,
  input wire logic [4:0]  dummy_cycles_o,
  input wire logic [1:0]  error_pin_condition_o,
  input wire logic [7:0]  check_chunk_bytes_o,
  input wire logic [15:0] preamble_pattern_o,
  input wire logic [15:0] preamble_pattern_line3_o,
  input wire logic        ecc_error_pin_n_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Values just after reset release
  a_reset_drive: assert property (@(posedge clock_i) disable iff (reset_i)
    $fell(reset_i) |-> drive_strength_sel_o == 3'h7 && !preamble_output_en_o)
    else $error("drive or preamble enable wrong after reset");
  a_reset_side: assert property (@(posedge clock_i) disable iff (reset_i)
    $fell(reset_i) |-> !protect_region_side_o && dummy_cycles_o == 5'h14)
    else $error("side or dummy count wrong after reset");
  // Set-only protect side
  a_side_sticky: assert property (@(posedge clock_i) disable iff (reset_i)
    protect_region_side_o |=> protect_region_side_o)
    else $error("protect side cleared without reset");
  // Legal derived figures
  a_dummy_legal: assert property (@(posedge clock_i) disable iff (reset_i)
    dummy_cycles_o >= 5'h06 && dummy_cycles_o <= 5'h14 && !dummy_cycles_o[0])
    else $error("dummy count outside its table");
  a_chunk_legal: assert property (@(posedge clock_i) disable iff (reset_i)
    check_chunk_bytes_o inside {8'h10, 8'h20, 8'h40, 8'h80})
    else $error("chunk size outside its table");
  a_pattern_pair: assert property (@(posedge clock_i) disable iff (reset_i)
    (preamble_pattern_o == 16'h349A && preamble_pattern_line3_o == 16'h3514) ||
    (preamble_pattern_o == 16'h5555 && preamble_pattern_line3_o == 16'h5555))
    else $error("preamble pattern pair wrong");
  // Two-bit error under condition 00 pulls the pin low
  a_pin_event: assert property (@(posedge clock_i) disable iff (reset_i)
    ecc_event_i && ecc_kind_i[1] && error_pin_condition_o == 2'h0
    |-> ##[1:3] !ecc_error_pin_n_o)
    else $error("error pin not driven low");
  // Unmapped read returns zero
  a_unmapped_zero: assert property (@(posedge link_clk_i) disable iff (link_reset_i)
    !rd_cfg_reg_i && rd_addr_i == 32'h00000100 |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");

  // Main scenarios
  c_ecc: cover property (@(posedge clock_i) ecc_event_i);
  c_pin: cover property (@(posedge clock_i) $fell(ecc_error_pin_n_o));
  c_side: cover property (@(posedge clock_i) $rose(protect_region_side_o));
endmodule

`default_nettype wire

// ### ocfg_host_model.sv
`default_nettype none

module ocfg_host_model (
  // Link clock and reset
  output logic        link_clk_o,
  output logic        link_reset_o,
  // Register access
  output logic        wr_status_o,
  output logic        wr_cfg2_o,
  output logic [31:0] wr_addr_o,
  output logic [7:0]  wr_data_o,
  output logic        rd_cfg_reg_o,
  output logic [31:0] rd_addr_o,
  input  wire logic [7:0]  rd_data_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus, clock stopped between frames
  initial begin
    {link_clk_o, wr_status_o, wr_cfg2_o, rd_cfg_reg_o} = 4'h0;
    link_reset_o = 1'b1;
    {wr_addr_o, wr_data_o, rd_addr_o} = 72'h0;
  end

  // Run link cycles, signals change at falling edges
  // Rising edge kept off the core clock's edges
  task automatic cyc(input int n);
    repeat (n) begin
      #6.2 link_clk_o = 1'b1;
      #8.8 link_clk_o = 1'b0;
    end
  endtask

  task automatic rst();
    link_reset_o = 1'b1;
    cyc(4);
    link_reset_o = 1'b0;
  endtask

  // One byte write, released data lines show inverse
  task automatic wr(input logic st, input logic [31:0] a, input logic [7:0] d);
    wr_status_o = st;
    wr_cfg2_o = !st;
    wr_addr_o = a;
    wr_data_o = d;
    cyc(1);
    {wr_status_o, wr_cfg2_o} = 2'h0;
    wr_addr_o = ~a;
    wr_data_o = ~d;
    cyc(6);
  endtask

  task automatic rd(input logic c, input logic [31:0] a, output logic [7:0] d);
    rd_cfg_reg_o = c;
    rd_addr_o = a;
    cyc(4);
    d = rd_data_i;
  endtask
endmodule

`default_nettype wire

// ### tb.sv
`default_nettype none

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (a), (e)); end end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ocfg_pkg::*;

  logic clock_i, reset_i, link_clk_i, link_reset_i, wr_status_i, wr_cfg2_i;
  logic [31:0] wr_addr_i, rd_addr_i;
  logic [7:0]  wr_data_i, rd_data_o, check_chunk_bytes_o, r;
  logic        rd_cfg_reg_i, ecc_event_i, ecc_upper_i, protect_region_side_o;
  logic [2:0]  ecc_kind_i, drive_strength_sel_o;
  logic        preamble_output_en_o, strobe_single_rate_en_o, strobe_precycle_o;
  logic        check_output_en_o, ecc_error_pin_n_o;
  ocfg_mode_t  interface_mode_o;
  logic [4:0]  dummy_cycles_o;
  logic [1:0]  error_pin_condition_o;
  logic [15:0] preamble_pattern_o, preamble_pattern_line3_o;
  int          mismatches = 0;
  int          checked = 0;

  ocfg_regs u_dut (.clock_i, .reset_i, .link_clk_i, .link_reset_i, .wr_status_i,
    .wr_cfg2_i, .wr_addr_i, .wr_data_i, .rd_cfg_reg_i, .rd_addr_i, .rd_data_o,
    .ecc_event_i, .ecc_upper_i, .ecc_kind_i, .drive_strength_sel_o,
    .protect_region_side_o, .preamble_output_en_o, .interface_mode_o,
    .strobe_single_rate_en_o, .strobe_precycle_o, .dummy_cycles_o,
    .error_pin_condition_o, .check_chunk_bytes_o, .check_output_en_o,
    .preamble_pattern_o, .preamble_pattern_line3_o, .ecc_error_pin_n_o);

  ocfg_host_model u_host (.link_clk_o(link_clk_i), .link_reset_o(link_reset_i),
    .wr_status_o(wr_status_i), .wr_cfg2_o(wr_cfg2_i), .wr_addr_o(wr_addr_i),
    .wr_data_o(wr_data_i), .rd_cfg_reg_o(rd_cfg_reg_i), .rd_addr_o(rd_addr_i),
    .rd_data_i(rd_data_o));

  // Core clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic rc(input logic c, input logic [31:0] a, input logic [7:0] e);
    u_host.rd(c, a, r);
    `CHK(r, e)
  endtask

  task automatic ev(input logic up, input logic [2:0] k);
    @(negedge clock_i);
    {ecc_event_i, ecc_upper_i, ecc_kind_i} = {1'b1, up, k};
    @(negedge clock_i);
    {ecc_event_i, ecc_kind_i} = 4'h0;
  endtask

  // Hang guard
  initial begin
    #20us;
    mismatches++;
    print_verdict();
  end

  initial begin
    reset_i = 1'b1;
    {ecc_event_i, ecc_upper_i, ecc_kind_i} = 5'h0;
    fork
      u_host.rst();
      begin repeat (2) @(negedge clock_i); reset_i = 1'b0; end
    join
    // Reset values
    rc(1'b1, 32'h0, 8'h07);
    rc(1'b0, 32'h00000200, 8'h00);
    rc(1'b0, 32'h00000300, 8'h00);
    rc(1'b0, 32'h00000400, 8'h00);
    rc(1'b0, 32'h04000800, 8'h00);
    rc(1'b0, 32'h00000000, 8'h00);
    rc(1'b0, 32'h00000500, 8'h00);
    rc(1'b0, 32'h00000800, 8'h00);
    `CHK({dummy_cycles_o, check_chunk_bytes_o}, {5'h14, 8'h10})
    `CHK({preamble_pattern_o, preamble_pattern_line3_o}, 32'h349A3514)
    `CHK({preamble_output_en_o, protect_region_side_o}, 2'h0)
    `CHK(ecc_error_pin_n_o, 1'b1)
    $display("test reset done");
    // Status command register
    u_host.wr(1'b1, 32'h0, 8'hFD);
    `CHK({preamble_output_en_o, protect_region_side_o, drive_strength_sel_o}, 5'h1D)
    u_host.wr(1'b1, 32'h0, 8'h02);
    rc(1'b1, 32'h0, 8'h0A);
    u_host.wr(1'b0, 32'h0, 8'h07);
    `CHK(drive_strength_sel_o, 3'h2)
    $display("test status done");
    // Modes, strobe, condition
    for (int s = 0; s < 4; s++) begin
      u_host.wr(1'b0, 32'h0, 8'hFC | 8'(s));
      `CHK(interface_mode_o, ocfg_mode_t'(s))
      u_host.wr(1'b0, 32'h400, 8'hFC | 8'(s));
      rc(1'b0, 32'h400, 8'(s));
      `CHK(error_pin_condition_o, 2'(s))
    end
    u_host.wr(1'b0, 32'h200, 8'hFE);
    `CHK({strobe_single_rate_en_o, strobe_precycle_o}, 2'h2)
    $display("test modes done");
    // Dummy count table
    for (int s = 0; s < 8; s++) begin
      u_host.wr(1'b0, 32'h300, 8'hF8 | 8'(s));
      `CHK(dummy_cycles_o, 5'(20 - 2 * s))
    end
    u_host.wr(1'b0, 32'h04000300, 8'h00);
    `CHK(dummy_cycles_o, 5'h06)
    // Check chunk, output enable, pattern
    for (int s = 0; s < 4; s++) begin
      r = {1'b1, 2'(s), s[0], 3'h7, s[0]};
      u_host.wr(1'b0, 32'h500, r);
      rc(1'b0, 32'h500, r & 8'h71);
      `CHK({check_chunk_bytes_o, check_output_en_o}, {8'h10 << s, s[0]})
      `CHK({preamble_pattern_o, preamble_pattern_line3_o}, s[0] ? 32'h55555555 : 32'h349A3514)
    end
    u_host.wr(1'b0, 32'h100, 8'hFF);
    rc(1'b0, 32'h100, 8'h00);
    $display("test config done");
    // Error status halves and counter
    u_host.wr(1'b0, 32'h400, 8'h00);
    u_host.wr(1'b0, 32'h800, 8'hFF);
    repeat (17) ev(1'b0, 3'h1);
    rc(1'b0, 32'h800, 8'h9F);
    rc(1'b0, 32'h04000800, 8'h00);
    `CHK(ecc_error_pin_n_o, 1'b1)
    ev(1'b1, 3'h2);
    rc(1'b0, 32'h04000800, 8'hA1);
    `CHK(ecc_error_pin_n_o, 1'b0)
    $display("test ecc done");
    print_verdict();
  end
endmodule

bind ocfg_regs ocfg_regs_checker u_chk (.clock_i, .reset_i, .link_clk_i, .link_reset_i,
  .rd_cfg_reg_i, .rd_addr_i, .rd_data_o, .ecc_event_i, .ecc_kind_i,
  .drive_strength_sel_o, .protect_region_side_o, .preamble_output_en_o,
  .dummy_cycles_o, .error_pin_condition_o, .check_chunk_bytes_o,
  .preamble_pattern_o, .preamble_pattern_line3_o, .ecc_error_pin_n_o);

`default_nettype wire
